// >>> design/trig_pkg.sv
package trig_pkg;

    // ------------------------------------------------------------------
    // register map (avalon word addresses as byte offsets)
    // ------------------------------------------------------------------
    localparam logic [3:0] ctrl_offset     = 4'h0;  // mode control
    localparam logic [3:0] status_offset   = 4'h4;  // live state
    localparam logic [3:0] count_offset    = 4'h8;  // readings stored
    localparam logic [3:0] trig_offset     = 4'hc;  // software trigger

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int store_en_bit    = 0;  // reading store enable
    localparam int one_shot_bit    = 1;  // one-shot request
    localparam int ext_trig_bit    = 2;  // ext_trig_mode_cmd
    localparam int ctrl_width      = 3;
    localparam logic [2:0] ctrl_reset = 3'h0;  // continuous at power-up

    // ------------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------------
    localparam int busy_bit        = 0;
    localparam int mode_bit        = 1;
    localparam int armed_bit       = 2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int clk_mhz         = 250;
    localparam int conv_time_us    = 20;   // conversion length
    localparam int conv_cycles     = conv_time_us * clk_mhz;
    localparam int pace_time_us    = 100;  // internal time base period
    localparam int pace_cycles     = pace_time_us * clk_mhz;
    localparam int done_pulse_ns   = 400;  // completion timer length; the pin stays low one cycle longer
    localparam int done_cycles     = (done_pulse_ns * clk_mhz + 999) / 1000;
    localparam int count_width     = 16;

endpackage

// >>> design/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // pin side
    input  wire logic pin_in,
    // falling edge seen
    output logic      fall_pulse
);
    // ------------------------------------------------------------------
    // two-stage synchroniser then edge detect
    // ------------------------------------------------------------------
    logic meta_reg;   // first stage, read only by sync_reg
    logic sync_reg;   // second stage
    logic last_reg;   // delayed copy for edge

    // pulled-up idle level is high, so reset to one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign fall_pulse = last_reg & ~sync_reg;
endmodule // edge_sync

// >>> design/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer #(
    parameter int cycles = 2
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // control
    input  wire logic start,
    // timer output
    output logic      running,
    output logic      expire
);
    // ------------------------------------------------------------------
    // one-shot down counter
    // ------------------------------------------------------------------
    localparam int cw = $clog2(cycles + 1);
    logic [cw-1:0] count_reg;  // cycles left

    // restart on start, count down to zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= cw'(cycles);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign running = (count_reg != '0);
    assign expire  = (count_reg == cw'(1));
endmodule // pulse_timer

// >>> design/reading_trigger_control.sv
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// (R1) power-up lands in continuous, timebase paced
// (R2) continuous mode reads back to back; code starts one at each time base tick while idle
// (R3) one reading per panel button press; code acts on the button in one-shot only
// (R4) one-shot needs store; store each reading
// (R5) external falling edge starts a reading
// (R6) one-shot: one per pulse, button too
// (R7) store disable returns to continuous
// (R8) external edges only with ext mode set
// (R9) one low completion pulse per reading
// (R10) continuous completion pulses follow conversions
// (R11) one-shot: one completion pulse per trigger
// (R12) far side debounces mechanical trigger switches
// (R13) ignore external edges during busy one-shot
module reading_trigger_control #(
    parameter int pace_count = trig_pkg::pace_cycles,
    parameter int conv_count = trig_pkg::conv_cycles
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // front panel and rear pins
    input  wire logic                 trigger_button,
    input  wire logic                 ext_trig_n,
    output logic                      reading_done_n,
    // reading engine
    output logic                      conv_start,
    output logic                      store_write,
    output logic [trig_pkg::count_width-1:0] store_index
);
    import trig_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_convert, st_finish} state_t;
    state_t state_reg;                 // reading sequencer
    logic [ctrl_width-1:0] ctrl_reg;   // mode control bits
    logic [count_width-1:0] count_reg; // stored reading count
    logic ack_reg;                     // bus answer phase
    logic [31:0] rdata_reg;            // read data hold
    logic sw_trig_reg;                 // software trigger pulse
    logic [31:0] pace_reg;             // time base counter
    logic pace_tick;                   // time base enable pulse
    logic button_fall;                 // button press, active low edge unused
    logic button_pulse;                // button press edge
    logic ext_fall;                    // external falling edge
    logic conv_run;                    // conversion timer running
    logic conv_done;                   // conversion finished
    logic done_run;                    // completion pulse active
    logic one_shot;                    // effective one-shot mode
    logic ext_mode;                    // external trigger enabled
    logic start_req;                   // a reading may start
    logic bus_cycle;                   // request presented

    // one-shot only exists while the store is enabled
    assign one_shot = ctrl_reg[store_en_bit] & ctrl_reg[one_shot_bit]; // R4 R7
    assign ext_mode = ctrl_reg[ext_trig_bit];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    edge_sync ext_sync (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pin_in     (ext_trig_n),
        .fall_pulse (ext_fall)
    );

    // button is active high: detect its rise via inverted input
    edge_sync btn_sync (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pin_in     (~trigger_button),
        .fall_pulse (button_fall)
    );
    assign button_pulse = button_fall;

    // ------------------------------------------------------------------
    // internal time base
    // ------------------------------------------------------------------
    // free-running divider, one-cycle enable per period
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pace_reg <= 32'h0;
        end else if (pace_reg == 32'(pace_count - 1)) begin
            pace_reg <= 32'h0;
        end else begin
            pace_reg <= pace_reg + 32'h1;
        end
    end
    assign pace_tick = (pace_reg == 32'(pace_count - 1));

    // ------------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------------
    // edges arriving while busy fall away; no queueing is kept, which
    // keeps one completion pulse per accepted trigger
    always_comb begin
        start_req = 1'b0;
        if (state_reg == st_idle) begin
            if (one_shot) begin
                start_req = button_pulse | sw_trig_reg; // R3 R6
                if (ext_mode && ext_fall) begin // R8 R13
                    start_req = 1'b1; // R5 R6
                end
            end else if (ext_mode) begin
                start_req = ext_fall; // R5 R8
            end else begin
                start_req = pace_tick; // R1 R2
            end
        end
    end

    // ------------------------------------------------------------------
    // conversion and completion timers
    // ------------------------------------------------------------------
    pulse_timer #(.cycles(conv_count)) conv_timer (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (start_req),
        .running (conv_run),
        .expire  (conv_done)
    );

    pulse_timer #(.cycles(done_cycles)) done_timer (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (conv_done),
        .running (done_run),
        .expire  ()
    );

    // ------------------------------------------------------------------
    // reading sequencer
    // ------------------------------------------------------------------
    // idle -> convert -> finish (completion pulse) -> idle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (start_req) begin
                        state_reg <= st_convert;
                    end
                end
                st_convert: begin
                    if (conv_done) begin
                        state_reg <= st_finish; // R10
                    end
                end
                st_finish: begin
                    // wait out the pulse so they never merge
                    if (!done_run) begin
                        state_reg <= st_idle;
                    end
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs to pins and reading engine
    // ------------------------------------------------------------------
    // registered strobes and low-going completion pulse
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_start     <= 1'b0;
            store_write    <= 1'b0;
            reading_done_n <= 1'b1;
        end else begin
            conv_start     <= start_req;
            store_write    <= conv_done & one_shot; // R4
            reading_done_n <= ~(done_run | conv_done); // R9 R11
        end
    end

    // store fill index, cleared when store is turned off
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= '0;
        end else if (!ctrl_reg[store_en_bit]) begin
            count_reg <= '0;
        end else if (conv_done && one_shot) begin
            count_reg <= count_reg + 1'b1; // R4
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            store_index <= '0;
        end else begin
            store_index <= count_reg;
        end
    end

    // ------------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------------
    // one wait cycle per access: answer on the second edge
    assign bus_cycle       = avs_read | avs_write;
    assign avs_waitrequest = bus_cycle & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_cycle & ~ack_reg;
        end
    end

    // control write; clearing store enable drops one-shot too
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg <= ctrl_reset; // R1
        end else if (avs_write && ack_reg && avs_address == ctrl_offset) begin
            ctrl_reg <= avs_writedata[ctrl_width-1:0];
            if (!avs_writedata[store_en_bit]) begin
                ctrl_reg[one_shot_bit] <= 1'b0; // R7
            end
        end
    end

    // software trigger acts as a button press
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sw_trig_reg <= 1'b0;
        end else begin
            // commits only at the edge where waitrequest is low
            sw_trig_reg <= avs_write & ack_reg & (avs_address == trig_offset)
                           & avs_writedata[0];
        end
    end

    // read mux, unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= 32'h0;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                ctrl_offset:   rdata_reg <= {29'h0, ctrl_reg};
                status_offset: rdata_reg <= {29'h0, ext_mode,
                                             one_shot, (state_reg != st_idle)};
                count_offset:  rdata_reg <= {16'h0, count_reg};
                default:       rdata_reg <= 32'h0;
            endcase
        end
    end

    // conv_run kept visible for tracing the timer
    logic unused_run;
    assign unused_run = conv_run;
endmodule // reading_trigger_control

// >>> dv/scanner_model.sv
`timescale 1ns/1ps
module scanner_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // bench command
    input  wire logic        fire,
    input  wire logic [3:0]  low_len,
    // pins
    input  wire logic        reading_done_n,
    output logic             ext_trig_n,
    output logic [15:0]      done_seen
);
    // ------------------------------------------------------
    // channel-ready pulse and completion count
    // ------------------------------------------------------
    logic [3:0] low_reg; // low cycles left
    logic       done_q;  // last completion level
    // clean single edge: a bouncing contact would retrigger
    always_ff @(posedge clk_sys) begin
        if (reset) low_reg <= 4'h0;
        else if (fire) low_reg <= low_len;
        else if (low_reg != 4'h0) low_reg <= low_reg - 4'h1;
    end
    assign ext_trig_n = (low_reg == 4'h0); // pulled up when released
    // each completion advances the scan by one channel
    always_ff @(posedge clk_sys) begin
        done_q <= reading_done_n;
        if (reset) done_seen <= 16'h0;
        else if (done_q && !reading_done_n) done_seen <= done_seen + 16'h1;
    end
endmodule // scanner_model

// >>> dv/reading_trigger_control_checker.sv
`timescale 1ns/1ps
module reading_trigger_control_checker #(
    parameter int pace_count = 40,
    parameter int conv_count = 10
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pins and engine
    input wire logic        trigger_button,
    input wire logic        ext_trig_n,
    input wire logic        reading_done_n,
    input wire logic        conv_start,
    input wire logic        store_write,
    input wire logic [trig_pkg::count_width-1:0] store_index
);
    import trig_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ------------------------------------------------------
    // helper state rebuilt from the ports
    // ------------------------------------------------------
    logic [2:0] sh_reg, prev_reg; // ctrl copy: ext, one-shot, store
    logic [3:0] age_reg;          // cycles since a trigger cause
    logic [7:0] low_reg;          // completion low time so far
    logic [1:0] run_reg;          // readings since last pulse end
    logic       busy_reg;         // reading in flight
    logic       wr_ok;            // write commits this edge
    assign wr_ok = avs_write && !avs_waitrequest;
    // store off also drops one-shot
    always_ff @(posedge clk_sys) begin
        prev_reg <= sh_reg;
        if (reset) sh_reg <= 3'h0;
        else if (wr_ok && avs_address == ctrl_offset)
            sh_reg <= {avs_writedata[2], &avs_writedata[1:0], avs_writedata[0]};
    end
    // causes: ext fall, button rise, soft trigger
    always_ff @(posedge clk_sys) begin
        if (reset || $fell(ext_trig_n) || $rose(trigger_button) ||
            (wr_ok && avs_address == trig_offset && avs_writedata[0]))
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    end
    // pulse width only judged when one reading owns the pulse
    always_ff @(posedge clk_sys) begin
        low_reg <= (reset || reading_done_n) ? 8'h0 : low_reg + 8'h1;
        if (reset) run_reg <= 2'h0;
        else if ($rose(reading_done_n)) run_reg <= {1'b0, conv_start};
        else if (conv_start && run_reg != 2'h3) run_reg <= run_reg + 2'h1;
        if (reset || ($rose(reading_done_n) && !conv_start)) busy_reg <= 1'b0;
        else if (conv_start) busy_reg <= 1'b1;
    end
    sequence s_wait_ack;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    chk_bus_wait: assert property ($rose(avs_read || avs_write) |-> s_wait_ack)
        else $error("bus answer not after one wait");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
        avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0) else $error("unmapped read");
    chk_status_mode: assert property (
        avs_read && !avs_waitrequest && avs_address == status_offset |->
        avs_readdata[mode_bit] == sh_reg[1] && avs_readdata[armed_bit] == sh_reg[2])
        else $error("status mode bits wrong");
    chk_conv_single: assert property (conv_start |=> !conv_start)
        else $error("start strobe too long");
    chk_store_oneshot: assert property (store_write |-> sh_reg[1])
        else $error("store outside one-shot");
    chk_pulse_width: assert property ($rose(reading_done_n) && run_reg == 2'h1 |->
        low_reg == 8'(done_cycles + 1)) else $error("completion width wrong");
    chk_done_follows: assert property (conv_start |-> ##[1:40] !reading_done_n)
        else $error("no completion after reading");
    chk_ext_react: assert property ($fell(ext_trig_n) && sh_reg[2] && !busy_reg |->
        ##[1:8] conv_start) else $error("ext edge ignored");
    chk_no_spurious: assert property (conv_start && (|sh_reg[2:1]) && (|prev_reg[2:1]) |->
        age_reg <= 4'h8) else $error("reading without trigger");
endmodule // reading_trigger_control_checker
bind reading_trigger_control reading_trigger_control_checker #(
    .pace_count(pace_count), .conv_count(conv_count)) checker_i (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .trigger_button, .ext_trig_n, .reading_done_n, .conv_start,
    .store_write, .store_index);

// >>> dv/tb_reading_trigger_control.sv
`timescale 1ns/1ps
module tb_reading_trigger_control;
    import trig_pkg::*;
    // ------------------------------------------------------
    // stimulus, design and far-side scanner
    // ------------------------------------------------------
    logic        clk_sys = 1'b0, reset = 1'b1, trigger_button = 1'b0, fire = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0]  avs_address = 4'h0, low_len = 4'h3;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        ext_trig_n, reading_done_n, conv_start, store_write;
    logic [15:0] store_index, done_seen;
    int          num_errors, checks, cyc, n_conv, n_store, b_conv, b_store, b_done;
    // short pace and conversion keep the run small
    reading_trigger_control #(.pace_count(40), .conv_count(10)) reading_trigger_control_i (
        .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .trigger_button, .ext_trig_n,
        .reading_done_n, .conv_start, .store_write, .store_index);
    scanner_model scanner_model_i (.clk_sys, .reset, .fire, .low_len, .reading_done_n,
        .ext_trig_n, .done_seen);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // strobe counters and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (!reset && conv_start === 1'b1) n_conv <= n_conv + 1;
        if (!reset && store_write === 1'b1) n_store <= n_store + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // one bus cycle; read data taken at the edge where waitrequest is low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(negedge clk_sys); while (avs_waitrequest !== 1'b0);
        @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic mark();
        b_conv = n_conv;
        b_store = n_store;
        b_done = done_seen;
    endtask
    // waits out one full reading, then compares counts since the mark
    task automatic settle(input int ec, input int es);
        repeat (250) @(posedge clk_sys);
        check(n_conv - b_conv, ec, "readings");
        check(n_store - b_store, es, "stored");
        check(done_seen - b_done, ec, "completions");
        mark();
    endtask
    // in-flight paced readings drain before counting starts
    task automatic mode(input logic [31:0] v);
        bus(1'b1, ctrl_offset, v);
        repeat (300) @(posedge clk_sys);
        mark();
    endtask
    task automatic press();
        @(posedge clk_sys);
        trigger_button <= 1'b1;
        repeat (4) @(posedge clk_sys);
        trigger_button <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] len);
        @(posedge clk_sys);
        low_len <= len;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        check(reading_done_n, 1'b1, "idle level");
        bus(1'b0, ctrl_offset, 32'h0);
        check(q, 32'h0, "ctrl at reset");
        mark();
        repeat (300) @(posedge clk_sys);
        check(n_conv - b_conv >= 2, 1'b1, "paced readings");
        check(done_seen - b_done >= 1, 1'b1, "paced completions");
        bus(1'b0, 4'h2, 32'h0);
        check(q, 32'h0, "unmapped read");
        mode(32'h3);
        bus(1'b0, status_offset, 32'h0);
        check(q[mode_bit], 1'b1, "one-shot active");
        settle(0, 0);
        press();
        settle(1, 1);
        bus(1'b1, trig_offset, 32'h1);
        settle(1, 1);
        pulse(4'hc);
        settle(0, 0);
        mode(32'h7);
        bus(1'b0, status_offset, 32'h0);
        check(q[2:0], 3'h6, "ext one-shot status");
        pulse(4'hc);
        settle(1, 1);
        pulse(4'h3);
        repeat (5) @(posedge clk_sys);
        pulse(4'h3);
        settle(1, 1);
        press();
        settle(1, 1);
        bus(1'b1, 4'h6, 32'hff);
        bus(1'b0, ctrl_offset, 32'h0);
        check(q, 32'h7, "ctrl after unmapped write");
        bus(1'b0, count_offset, 32'h0);
        check(q, 32'h5, "stored count");
        check(store_index, 32'h5, "store index");
        mode(32'h4);
        settle(0, 0);
        pulse(4'h3);
        settle(1, 0);
        mode(32'h3);
        bus(1'b1, ctrl_offset, 32'h2);
        bus(1'b0, ctrl_offset, 32'h0);
        check(q, 32'h0, "store off ends one-shot");
        mark();
        repeat (300) @(posedge clk_sys);
        check(n_conv - b_conv >= 2, 1'b1, "paced again");
        conclude();
    end
endmodule // tb_reading_trigger_control
